// [src/crs_core.sv]
// call and return stack instruction execution with apb status access
//
// Contract
// RULE1: push writes pc plus two as top
// RULE2: relative call opcode top bits 11011
// RULE3: relative call pushes pc plus two first
// RULE4: call target pc plus two plus 2n
// RULE5: offset ranges minus 1024 to 1023
// RULE6: soft reset in Q2 clears core state
// RULE7: return from interrupt pops into pc at Q4
// RULE8: return from interrupt sets one enable bit
// RULE9: fast bit restores acc, flags, bank
// RULE10: fast bit clear leaves them unchanged
// RULE11: return from interrupt decoded with fast bit
// RULE12: pc latches untouched by return
// RULE13: return literal writes acc at Q4
// RULE14: return literal pops into pc
// RULE15: call and returns take two cycles
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module crs_core
(
    input wire logic pclk, // clock, 20 MHz
    input wire logic presetn, // async reset, active low
    input wire crs_pkg::crs_apb_req_type apb_req, // apb request
    output crs_pkg::crs_apb_rsp_type apb_rsp, // apb answer
    input wire logic [15:0] instr_word, // instruction, sampled at Q1
    input wire logic external_master_clear, // sync core reset request
    input wire logic return_to_high, // return re-enables high priority
    input wire crs_pkg::crs_shadow_type shadow_in, // shadow acc, flags, bank
    output logic [crs_pkg::PC_W-1:0] program_counter, // instruction address
    output logic [crs_pkg::PC_W-1:0] stack_top_entry, // current top of stack
    output logic [crs_pkg::SP_W-1:0] stack_level, // stack pointer
    output logic [7:0] accumulator, // working register
    output logic [7:0] status_reg, // status flags
    output logic [7:0] bank_select_reg, // bank select
    output logic high_prio_int_enable, // global high enable
    output logic low_prio_int_enable, // global low enable
    output logic [1:0] quarter_phase, // current phase
    output logic soft_reset_pulse // one cycle, reset started by software
);
    typedef struct packed {
        logic run;
        crs_pkg::crs_phase_type q;
        logic second;
        logic [15:0] ir;
        logic [crs_pkg::PC_W-1:0] pc;
        logic [crs_pkg::SP_W-1:0] sp;
        logic [7:0] acc;
        logic [7:0] flags;
        logic [7:0] bank;
        logic en_hi;
        logic en_lo;
        logic rst_pulse;
        logic [31:0] prdata;
        logic pslverr;
    } crs_state_type;

    crs_state_type st;
    crs_state_type next_st;

    logic is_push;
    logic is_call;
    logic is_reset;
    logic is_ret_int;
    logic is_ret_lit;
    logic [crs_pkg::PC_W-1:0] call_disp;
    logic [crs_pkg::PC_W-1:0] top;
    logic wr_en;
    logic [crs_pkg::SP_W-1:0] wr_addr;
    logic [crs_pkg::SP_W-1:0] sp_up;
    logic [crs_pkg::SP_W-1:0] sp_down;
    logic setup;

    // decode of the latched instruction
    assign is_push = st.ir == crs_pkg::OP_PUSH; // RULE1
    assign is_call = st.ir[15:11] == crs_pkg::OP_REL_CALL_HI; // RULE2
    assign is_reset = st.ir == crs_pkg::OP_SOFT_RESET;
    assign is_ret_int = st.ir[15:1] == crs_pkg::OP_RET_INT_HI; // RULE11
    assign is_ret_lit = st.ir[15:8] == crs_pkg::OP_RET_LIT_HI;
    // sign-extended word offset, doubled to a byte step
    assign call_disp = {{(crs_pkg::PC_W-crs_pkg::OFS_W-1){st.ir[10]}}, st.ir[10:0], 1'b0}; // RULE5

    assign sp_up = (st.sp == crs_pkg::SP_FULL) ? st.sp : st.sp + 5'h01;
    assign sp_down = (st.sp == crs_pkg::SP_RESET) ? st.sp : st.sp - 5'h01;
    // push slot written at Q2 for push and call
    assign wr_en = st.run && st.q == crs_pkg::Q2 && !st.second && (is_push || is_call); // RULE1 RULE3
    assign wr_addr = sp_up;
    assign setup = apb_req.psel && !apb_req.penable;

    crs_stack_mem i_crs_stack_mem
    (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(st.pc + crs_pkg::PC_STEP),
        .rd_addr(st.sp),
        .rd_data(top)
    );

    always_comb
    begin
        next_st = st;
        next_st.rst_pulse = 1'b0;
        // apb: registers answer in the access phase, data captured at setup
        if (setup)
        begin
            next_st.pslverr = 1'b0;
            next_st.prdata = 32'h00000000;
            case (apb_req.paddr)
                crs_pkg::REG_CTRL: next_st.prdata[crs_pkg::CTRL_RUN_BIT] = st.run;
                crs_pkg::REG_STATUS: next_st.prdata = {21'h000000, st.en_hi, st.en_lo, st.second, st.sp, st.q, st.run};
                crs_pkg::REG_PC: next_st.prdata = {11'h000, st.pc};
                crs_pkg::REG_ACC: next_st.prdata = {8'h00, st.bank, st.flags, st.acc};
                crs_pkg::REG_TOP: next_st.prdata = {11'h000, top};
                default: next_st.pslverr = 1'b1;
            endcase
        end
        if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == crs_pkg::REG_CTRL)
        begin
            next_st.run = apb_req.pwdata[crs_pkg::CTRL_RUN_BIT];
        end
        if (st.run)
        begin
            next_st.q = crs_pkg::crs_phase_type'(st.q + 2'b01);
            case (st.q)
                crs_pkg::Q1:
                begin
                    // second cycle executes as a no-op while fetch refills
                    next_st.ir = st.second ? crs_pkg::OP_NOP : instr_word; // RULE15
                end
                crs_pkg::Q2:
                begin
                    if (is_push || is_call)
                    begin
                        next_st.sp = sp_up; // RULE1 RULE3
                    end
                end
                crs_pkg::Q3:
                begin
                end
                crs_pkg::Q4:
                begin
                    // the refill cycle keeps pc on the new target
                    next_st.pc = st.second ? st.pc : st.pc + crs_pkg::PC_STEP; // RULE15
                    next_st.second = 1'b0;
                    if (is_call)
                    begin
                        next_st.pc = st.pc + crs_pkg::PC_STEP + call_disp; // RULE4
                        next_st.second = 1'b1; // RULE15
                    end
                    if (is_ret_int || is_ret_lit)
                    begin
                        // only pc reloads; the pc latches live elsewhere
                        next_st.pc = top; // RULE7 RULE12 RULE14
                        next_st.sp = sp_down; // RULE7 RULE14
                        next_st.second = 1'b1; // RULE15
                    end
                    if (is_ret_int)
                    begin
                        if (return_to_high)
                        begin
                            next_st.en_hi = 1'b1; // RULE8
                        end
                        else
                        begin
                            next_st.en_lo = 1'b1; // RULE8
                        end
                        if (st.ir[0]) // RULE10
                        begin
                            next_st.acc = shadow_in.acc; // RULE9
                            next_st.flags = shadow_in.flags; // RULE9
                            next_st.bank = shadow_in.bank; // RULE9
                        end
                    end
                    if (is_ret_lit)
                    begin
                        next_st.acc = st.ir[7:0]; // RULE13
                    end
                end
                default:
                begin
                end
            endcase
        end
        // software reset starts at Q2, same state clear as the external clear, plus the reset pulse
        if (external_master_clear || (st.run && st.q == crs_pkg::Q2 && is_reset)) // RULE6
        begin
            next_st.rst_pulse = !external_master_clear;
            next_st.q = crs_pkg::Q1;
            next_st.second = 1'b0;
            next_st.ir = crs_pkg::OP_NOP;
            next_st.pc = crs_pkg::PC_RESET;
            next_st.sp = crs_pkg::SP_RESET;
            next_st.acc = crs_pkg::ACC_RESET;
            next_st.flags = crs_pkg::FLAGS_RESET;
            next_st.bank = crs_pkg::BANK_RESET;
            next_st.en_hi = 1'b0;
            next_st.en_lo = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st.run <= crs_pkg::CTRL_RUN_RESET;
            st.q <= crs_pkg::Q1;
            st.second <= 1'b0;
            st.ir <= crs_pkg::OP_NOP;
            st.pc <= crs_pkg::PC_RESET;
            st.sp <= crs_pkg::SP_RESET;
            st.acc <= crs_pkg::ACC_RESET;
            st.flags <= crs_pkg::FLAGS_RESET;
            st.bank <= crs_pkg::BANK_RESET;
            st.en_hi <= 1'b0;
            st.en_lo <= 1'b0;
            st.rst_pulse <= 1'b0;
            st.prdata <= 32'h00000000;
            st.pslverr <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign apb_rsp.prdata = st.prdata;
    assign apb_rsp.pslverr = st.pslverr && apb_req.psel && apb_req.penable;
    assign apb_rsp.pready = apb_req.psel && apb_req.penable;
    assign program_counter = st.pc;
    assign stack_top_entry = top;
    assign stack_level = st.sp;
    assign accumulator = st.acc;
    assign status_reg = st.flags;
    assign bank_select_reg = st.bank;
    assign high_prio_int_enable = st.en_hi;
    assign low_prio_int_enable = st.en_lo;
    assign quarter_phase = st.q;
    assign soft_reset_pulse = st.rst_pulse;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || external_master_clear);

    logic exec_q2;
    logic exec_q4;
    assign exec_q2 = st.run && st.q == crs_pkg::Q2 && !st.second;
    assign exec_q4 = st.run && st.q == crs_pkg::Q4 && !st.second;

    sequence nop_cycle_s;
        (st.second && st.run) [*4];
    endsequence

    sequence pc_frozen_s;
        $stable(st.pc) [*4];
    endsequence

    push_top_value_a: assert property (exec_q2 && is_push && st.sp != crs_pkg::SP_FULL
        |-> ##2 (top == st.pc + crs_pkg::PC_STEP) && st.sp == $past(st.sp, 2) + 5'h01) // RULE1
        else $error("push did not place pc plus two on top");
    call_push_a: assert property (exec_q2 && is_call && st.sp != crs_pkg::SP_FULL
        |-> ##2 top == st.pc + crs_pkg::PC_STEP) // RULE3
        else $error("call did not push return address");
    call_target_a: assert property (exec_q4 && st.ir[15:11] == 5'h1B
        |=> st.pc == $past(st.pc) + 21'h000002
            + {{9{$past(st.ir[10])}}, $past(st.ir[10:0]), 1'b0}) // RULE2 RULE4 RULE5
        else $error("call target wrong");
    soft_reset_a: assert property (st.run && st.q == crs_pkg::Q2 && is_reset
        |=> st.pc == crs_pkg::PC_RESET && st.sp == crs_pkg::SP_RESET && !st.en_hi && !st.en_lo
            && st.acc == crs_pkg::ACC_RESET && soft_reset_pulse) // RULE6
        else $error("software reset did not clear core");
    int_return_pop_a: assert property (exec_q4 && is_ret_int && st.sp != crs_pkg::SP_RESET
        |=> st.pc == $past(top) && st.sp == $past(st.sp) - 5'h01) // RULE7 RULE12
        else $error("return from interrupt pop wrong");
    int_return_enable_a: assert property (exec_q4 && is_ret_int
        |=> ($past(return_to_high) ? (st.en_hi && st.en_lo == $past(st.en_lo))
            : (st.en_lo && st.en_hi == $past(st.en_hi)))) // RULE8
        else $error("interrupt enable not set on return");
    fast_restore_a: assert property (exec_q4 && is_ret_int && st.ir[0]
        |=> {st.acc, st.flags, st.bank} == $past(shadow_in)) // RULE9
        else $error("shadow restore missing");
    keep_context_a: assert property (exec_q4 && is_ret_int && !st.ir[0]
        |=> $stable(st.acc) && $stable(st.flags) && $stable(st.bank)) // RULE10
        else $error("context changed without fast bit");
    literal_return_a: assert property (exec_q4 && is_ret_lit
        |=> st.acc == $past(st.ir[7:0]) && st.pc == $past(top) && $stable(st.flags)) // RULE13 RULE14
        else $error("return literal wrong");
    two_cycle_a: assert property (exec_q4 && (is_call || is_ret_int || is_ret_lit)
        |=> nop_cycle_s ##0 1'b1 and (##1 pc_frozen_s)) // RULE15
        else $error("second cycle not idle");
endmodule
`default_nettype wire

// [include/crs_pkg.sv]
// package: constants and carrier types for the call and return stack control block
package crs_pkg;

    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int DEPTH = 32;
    localparam int OFS_W = 11;

    // opcode patterns
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_SOFT_RESET = 16'h00FF;
    localparam logic [15:0] OP_NOP = 16'h0000;
    localparam logic [14:0] OP_RET_INT_HI = 15'h0008;
    localparam logic [7:0] OP_RET_LIT_HI = 8'h0C;
    localparam logic [4:0] OP_REL_CALL_HI = 5'h1B;

    // reset values, full stack pointer and pc step
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [SP_W-1:0] SP_RESET = 5'h00;
    localparam logic [SP_W-1:0] SP_FULL = 5'h1F;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

    // apb register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PC = 8'h08;
    localparam logic [7:0] REG_ACC = 8'h0C;
    localparam logic [7:0] REG_TOP = 8'h10;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'b0;

    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b10,
        Q4 = 2'b11
    } crs_phase_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } crs_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } crs_apb_rsp_type;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [7:0] bank;
    } crs_shadow_type;

endpackage

// [src/crs_stack_mem.sv]
// return stack storage with registered read port
`timescale 1ns/1ps
`default_nettype none
module crs_stack_mem
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic wr_en, // write strobe
    input wire logic [crs_pkg::SP_W-1:0] wr_addr, // write index
    input wire logic [crs_pkg::PC_W-1:0] wr_data, // write entry
    input wire logic [crs_pkg::SP_W-1:0] rd_addr, // read index
    output logic [crs_pkg::PC_W-1:0] rd_data // registered read entry
);
    logic [crs_pkg::PC_W-1:0] mem [crs_pkg::DEPTH];

    always_ff @(posedge pclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // write-through returns the new entry when the write index equals the read index, as on a push to a full stack
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data <= crs_pkg::PC_RESET;
        end
        else if (wr_en && wr_addr == rd_addr)
        begin
            rd_data <= wr_data;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// [bench/tb_crs_core.sv]
// self-checking testbench for the call and return stack control block
`timescale 1ns/1ps
`default_nettype none
module tb_crs_core;
    logic pclk;
    logic presetn;
    crs_pkg::crs_apb_req_type req;
    crs_pkg::crs_apb_rsp_type rsp;
    logic [15:0] instr_word;
    logic external_master_clear;
    logic return_to_high;
    crs_pkg::crs_shadow_type shadow_in;
    logic [crs_pkg::PC_W-1:0] program_counter;
    logic [crs_pkg::PC_W-1:0] stack_top_entry;
    logic [crs_pkg::SP_W-1:0] stack_level;
    logic [7:0] accumulator;
    logic [7:0] status_reg;
    logic [7:0] bank_select_reg;
    logic high_prio_int_enable;
    logic low_prio_int_enable;
    logic [1:0] quarter_phase;
    logic soft_reset_pulse;
    // expected core state
    logic [crs_pkg::PC_W-1:0] stk [0:31];
    logic [crs_pkg::PC_W-1:0] m_pc;
    logic [4:0] m_sp;
    logic [7:0] m_acc;
    logic [7:0] m_flg;
    logic [7:0] m_bank;
    logic m_hi;
    logic m_lo;
    logic [31:0] rd;
    logic er;
    int err_count;
    int checked;
    int cyc;
    int i;

    crs_core i_crs_core
    (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(req),
        .apb_rsp(rsp),
        .instr_word(instr_word),
        .external_master_clear(external_master_clear),
        .return_to_high(return_to_high),
        .shadow_in(shadow_in),
        .program_counter(program_counter),
        .stack_top_entry(stack_top_entry),
        .stack_level(stack_level),
        .accumulator(accumulator),
        .status_reg(status_reg),
        .bank_select_reg(bank_select_reg),
        .high_prio_int_enable(high_prio_int_enable),
        .low_prio_int_enable(low_prio_int_enable),
        .quarter_phase(quarter_phase),
        .soft_reset_pulse(soft_reset_pulse)
    );

    always #25 pclk = ~pclk;

    task end_sim;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            end_sim;
        end
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk, input logic xe);
        apb(1'b0, a, 32'h00000000);
        chk("prdata", rd & msk, exp);
        chk("pslverr", {31'h00000000, er}, {31'h00000000, xe});
    endtask

    task mpush(input logic [crs_pkg::PC_W-1:0] v);
        if (m_sp != 5'h1F)
            m_sp = m_sp + 5'h01;
        stk[m_sp] = v;
    endtask

    task mpop;
        m_pc = stk[m_sp];
        if (m_sp != 5'h00)
            m_sp = m_sp - 5'h01;
    endtask

    task mzero;
        m_pc = '0;
        m_sp = 5'h00;
        m_acc = 8'h00;
        m_flg = 8'h00;
        m_bank = 8'h00;
        m_hi = 1'b0;
        m_lo = 1'b0;
    endtask

    task st;
        chk("pc", 32'(program_counter), 32'(m_pc));
        chk("sp", 32'(stack_level), 32'(m_sp));
        if (m_sp != 5'h00)
            chk("stack top", 32'(stack_top_entry), 32'(stk[m_sp]));
        chk("acc", 32'(accumulator), 32'(m_acc));
        chk("flags", 32'(status_reg), 32'(m_flg));
        chk("bank", 32'(bank_select_reg), 32'(m_bank));
        chk("enables", {30'h00000000, high_prio_int_enable, low_prio_int_enable}, {30'h00000000, m_hi, m_lo});
    endtask

    // launch one opcode at the start of Q1; calls and returns are followed by exactly one no-op cycle
    task exec(input logic [15:0] op);
        int e;
        logic [crs_pkg::PC_W-1:0] ret;
        do
        begin
            @(posedge pclk);
        end
        while (quarter_phase !== 2'h3);
        instr_word <= op;
        m_pc = m_pc + crs_pkg::PC_STEP;
        ret = m_pc + crs_pkg::PC_STEP;
        e = 8;
        casez (op)
            16'h0005:
            begin
                mpush(ret);
                m_pc = ret;
                e = 4;
            end
            16'b11011???????????:
            begin
                mpush(ret);
                m_pc = ret + {{9{op[10]}}, op[10:0], 1'b0};
            end
            16'h00FF:
            begin
                mzero;
                e = 2;
            end
            16'b000000000001000?:
            begin
                mpop;
                m_hi = m_hi | return_to_high;
                m_lo = m_lo | ~return_to_high;
                if (op[0])
                    {m_acc, m_flg, m_bank} = shadow_in;
            end
            16'h0C??:
            begin
                mpop;
                m_acc = op[7:0];
            end
            default:
            begin
                m_pc = ret;
                e = 4;
            end
        endcase
        @(posedge pclk);
        instr_word <= crs_pkg::OP_NOP;
        repeat ((e == 8) ? 3 : e - 1) @(posedge pclk);
        if (e == 8)
        begin
            // a push offered during the no-op cycle must be ignored
            instr_word <= crs_pkg::OP_PUSH;
            @(negedge pclk);
            chk("pc after first cycle", 32'(program_counter), 32'(m_pc));
            @(posedge pclk);
            instr_word <= crs_pkg::OP_NOP;
            repeat (3) @(posedge pclk);
        end
        @(negedge pclk);
        st;
        if (e == 2)
        begin
            chk("reset pulse", 32'(soft_reset_pulse), 32'h00000001);
            chk("phase", 32'(quarter_phase), 32'h00000000);
        end
    endtask

    task setin(input logic hi, input logic [23:0] sh);
        @(posedge pclk);
        return_to_high <= hi;
        shadow_in <= sh;
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        req = '0;
        instr_word = crs_pkg::OP_NOP;
        external_master_clear = 1'b0;
        return_to_high = 1'b0;
        shadow_in = '0;
        err_count = 0;
        checked = 0;
        cyc = 0;
        mzero;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(crs_pkg::REG_CTRL, 32'h00000000, 32'hFFFFFFFF, 1'b0);
        rdchk(crs_pkg::REG_STATUS, 32'h00000000, 32'hFFFFFFFF, 1'b0);
        rdchk(crs_pkg::REG_ACC, 32'h00000000, 32'hFFFFFFFF, 1'b0);
        rdchk(8'h14, 32'h00000000, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, crs_pkg::REG_PC, 32'h00000123);
        rdchk(crs_pkg::REG_PC, 32'h00000000, 32'hFFFFFFFF, 1'b0);
        apb(1'b1, crs_pkg::REG_CTRL, 32'h00000001);
        rdchk(crs_pkg::REG_CTRL, 32'h00000001, 32'hFFFFFFFF, 1'b0);
        exec(crs_pkg::OP_SOFT_RESET);
        exec(crs_pkg::OP_PUSH);
        exec(crs_pkg::OP_PUSH);
        exec(16'hDBFF);
        exec(16'hDC00);
        exec(16'hDFFF);
        exec(16'h0CA5);
        exec(16'h0CFF);
        setin(1'b1, 24'hA1B2C3);
        exec(16'h0011);
        setin(1'b0, 24'h5A6B7C);
        exec(16'h0010);
        @(posedge pclk);
        external_master_clear <= 1'b1;
        repeat (3) @(posedge pclk);
        external_master_clear <= 1'b0;
        @(negedge pclk);
        mzero;
        st;
        for (i = 0; i < 33; i++)
            exec(crs_pkg::OP_PUSH);
        apb(1'b1, crs_pkg::REG_CTRL, 32'h00000000);
        rdchk(crs_pkg::REG_STATUS, {21'h000000, m_hi, m_lo, 1'b0, m_sp, 3'h0}, 32'hFFFFFFF9, 1'b0);
        rdchk(crs_pkg::REG_PC, 32'(m_pc), 32'hFFFFFFFF, 1'b0);
        rdchk(crs_pkg::REG_TOP, 32'(stk[m_sp]), 32'hFFFFFFFF, 1'b0);
        rdchk(crs_pkg::REG_ACC, {8'h00, m_bank, m_flg, m_acc}, 32'hFFFFFFFF, 1'b0);
        end_sim;
    end
endmodule
`default_nettype wire
